// File: verilog/arf_pkg.sv
// Shared constants, types and helpers for the converter result block
package arf_pkg;

	// Bus geometry
	localparam int ARF_DATA_W = 32; // Avalon data width
	localparam int ARF_ADDR_W = 5; // Byte address width

	// Register byte offsets
	localparam logic [4:0] ARF_OFF_CTRL0 = 5'h00; // converter_control_zero
	localparam logic [4:0] ARF_OFF_CTRL1 = 5'h04; // converter_control_one
	localparam logic [4:0] ARF_OFF_RESH = 5'h08; // result_high_byte
	localparam logic [4:0] ARF_OFF_RESL = 5'h0C; // result_low_byte
	localparam logic [4:0] ARF_OFF_ISTAT = 5'h10; // Sticky event status
	localparam logic [4:0] ARF_OFF_ICLR = 5'h14; // Write-one clear
	localparam logic [4:0] ARF_OFF_IEN = 5'h18; // Interrupt enable

	// converter_control_zero fields
	localparam int ARF_ON_BIT = 0; // converter_on
	localparam int ARF_GO_BIT = 1; // Go / busy
	localparam int ARF_CHS_LSB = 2; // input_channel_select low bit
	localparam int ARF_CHS_W = 5; // input_channel_select width

	// converter_control_one fields
	localparam int ARF_JUST_BIT = 7; // result_justify_select
	localparam int ARF_CLK_LSB = 4; // Conversion clock select low bit
	localparam int ARF_CLK_W = 3; // Conversion clock select width
	localparam int ARF_REF_LSB = 0; // Reference select low bit
	localparam int ARF_REF_W = 3; // Reference select width

	// Result geometry
	localparam int ARF_RES_W = 10; // Conversion result width
	localparam int ARF_BYTE_W = 8; // Result byte width
	localparam int ARF_PAD_W = 6; // Zero pad bits in a result byte
	localparam logic [3:0] ARF_TOP_BIT = 4'h9; // First bit the SAR decides
	localparam logic [9:0] ARF_RES_ZERO = 10'h000; // Empty result

	// Event bits
	localparam int ARF_IRQ_W = 2; // Number of event bits
	localparam int ARF_EV_DONE = 0; // conversion_done_flag
	localparam int ARF_EV_ABORT = 1; // Conversion stopped by software

	// Reset values
	localparam logic [7:0] ARF_BYTE_ZERO = 8'h00; // Control bytes at reset
	localparam logic [31:0] ARF_WORD_ZERO = 32'h00000000; // Empty read word

	// Conversion clock select codes and divide ratios
	localparam logic [6:0] ARF_DIV2 = 7'h02;
	localparam logic [6:0] ARF_DIV4 = 7'h04;
	localparam logic [6:0] ARF_DIV8 = 7'h08;
	localparam logic [6:0] ARF_DIV16 = 7'h10;
	localparam logic [6:0] ARF_DIV32 = 7'h20;
	localparam logic [6:0] ARF_DIV64 = 7'h40;

	// Controller states, one-hot
	typedef enum logic [2:0] {
		ARF_ST_IDLE = 3'b001,
		ARF_ST_CONV = 3'b010,
		ARF_ST_LOAD = 3'b100
	} arf_state_e;

	// The two result bytes as loaded together
	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} arf_result_s;

	// Place a 10-bit result into the bytes under the justify bit
	function automatic arf_result_s arf_format(input logic [9:0] val,
		input logic rightJust);
		arf_result_s r;
		if (rightJust)
		begin
			r.hi = {{ARF_PAD_W{1'b0}}, val[9:8]};
			r.lo = val[7:0];
		end
		else
		begin
			r.hi = val[9:2];
			r.lo = {val[1:0], {ARF_PAD_W{1'b0}}};
		end
		return r;
	endfunction

endpackage

// File: verilog/arf_result_regs.sv
// Converter control, SAR sequencer and justified result bytes
`timescale 1ns/1ps

module arf_result_regs #(
	parameter logic [6:0] FRC_DIV = 7'h04 // Divide standing in for RC clock
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Avalon-MM slave
	input wire logic [arf_pkg::ARF_ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [arf_pkg::ARF_DATA_W-1:0] writedata,
	output logic [arf_pkg::ARF_DATA_W-1:0] readdata,
	output logic waitrequest,
	// Interrupt
	output logic irq,
	// Analog front end
	input wire logic cmpIn,
	output logic [arf_pkg::ARF_RES_W-1:0] dacCode,
	output logic [arf_pkg::ARF_CHS_W-1:0] inputChannelSelect,
	output logic [arf_pkg::ARF_REF_W-1:0] refSelect,
	output logic converterOn
);
	import arf_pkg::*;
	// Control state
	logic onReg; // converter_on
	logic goReg; // Go / busy
	logic [ARF_CHS_W-1:0] chanReg; // Channel select
	logic justReg; // result_justify_select
	logic [ARF_CLK_W-1:0] clkSelReg; // Conversion clock select
	logic [ARF_REF_W-1:0] refReg; // Reference select
	// Result bytes, deliberately without reset
	logic [ARF_BYTE_W-1:0] resHiReg;
	logic [ARF_BYTE_W-1:0] resLoReg;
	// Events
	logic [ARF_IRQ_W-1:0] statReg; // Sticky status
	logic [ARF_IRQ_W-1:0] enReg; // Enable mask
	logic irqReg; // Interrupt level
	// Bus
	logic waitReg; // High except in the answer cycle
	logic [ARF_DATA_W-1:0] rdataReg; // Read data
	// Sequencer
	arf_state_e stateReg; // Controller state
	logic [3:0] bitIdxReg; // Bit under trial
	logic [ARF_RES_W-1:0] sarReg; // Trial code to the DAC
	logic lastBitReg; // Value of the last decided bit
	logic [ARF_RES_W-1:0] loadValReg; // Value waiting to be loaded
	logic loadAbortReg; // Load stems from an abort
	logic [6:0] divCntReg; // Bit clock divider
	// Comparator synchroniser
	logic cmpMeta;
	logic cmpSync;
	// Decoded strobes
	logic wrAcc; // Write taken this edge
	logic rdFirst; // Read seen in its first cycle
	logic lane0; // Low byte lane enabled
	logic ctrl0Wr; // Write to converter_control_zero
	logic startReq; // Conversion start accepted
	logic abortReq; // Conversion stopped by software
	logic tick; // One conversion bit period elapsed
	logic [6:0] divLimit; // Current divide ratio
	logic [ARF_RES_W-1:0] bitMask; // One-hot of trial bit
	logic [ARF_RES_W-1:0] belowMask; // Trial bit and all below
	logic [ARF_RES_W-1:0] decided; // Code after deciding trial bit
	logic [ARF_RES_W-1:0] partial; // Code filled after abort
	arf_result_s fmt; // Formatted result bytes
	// Divide ratio for each clock select code
	function automatic logic [6:0] arfDivOf(input logic [2:0] code);
		case (code)
			3'h0: return ARF_DIV2;
			3'h1: return ARF_DIV8;
			3'h2: return ARF_DIV32;
			3'h4: return ARF_DIV4;
			3'h5: return ARF_DIV16;
			3'h6: return ARF_DIV64;
			default: return FRC_DIV; // Both RC codes
		endcase
	endfunction
	// One-hot mask of a result bit
	function automatic logic [9:0] arfMask(input logic [3:0] idx);
		logic [9:0] m;
		m = 10'h001 << idx;
		return m;
	endfunction
	// Bus decode, combinational
	always_comb
	begin
		wrAcc = write && !waitReg;
		rdFirst = read && waitReg;
		lane0 = byteenable[0];
		ctrl0Wr = wrAcc && lane0 && (address == ARF_OFF_CTRL0);
		// Go ignored unless the converter was already on
		startReq = ctrl0Wr && writedata[ARF_GO_BIT] && onReg
			&& (stateReg == ARF_ST_IDLE);
		abortReq = ctrl0Wr && (stateReg == ARF_ST_CONV)
			&& (!writedata[ARF_GO_BIT] || !writedata[ARF_ON_BIT]);
	end
	// SAR arithmetic, combinational
	always_comb
	begin
		divLimit = arfDivOf(clkSelReg);
		tick = (divCntReg == divLimit - 7'h01);
		bitMask = arfMask(bitIdxReg);
		belowMask = 10'({bitMask[8:0], 1'b0} - 10'h001);
		decided = cmpSync ? sarReg : (sarReg & ~bitMask);
		// Unconverted bits copy the last decided bit
		partial = (sarReg & ~belowMask)
			| (lastBitReg ? belowMask : ARF_RES_ZERO);
		fmt = arf_format(loadValReg, justReg);
	end
	// Comparator input synchroniser
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			cmpMeta <= 1'b0;
			cmpSync <= 1'b0;
		end
		else
		begin
			cmpMeta <= cmpIn;
			cmpSync <= cmpMeta;
		end
	end
	// Bus answer: one wait cycle, then data with waitrequest low
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			waitReg <= 1'b1;
			rdataReg <= ARF_WORD_ZERO;
		end
		else
		begin
			waitReg <= !((read || write) && waitReg);
			if (rdFirst)
			begin
				case (address)
					ARF_OFF_CTRL0: rdataReg <= 32'({chanReg, goReg, onReg});
					ARF_OFF_CTRL1: rdataReg <= 32'({justReg, clkSelReg,
						1'b0, refReg});
					ARF_OFF_RESH: rdataReg <= 32'(resHiReg);
					ARF_OFF_RESL: rdataReg <= 32'(resLoReg);
					ARF_OFF_ISTAT: rdataReg <= 32'(statReg);
					ARF_OFF_IEN: rdataReg <= 32'(enReg);
					default: rdataReg <= ARF_WORD_ZERO; // Unmapped or write-only clear, reads zero
				endcase
			end
		end
	end
	// converter_control_zero: channel, enable and go / busy
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			onReg <= 1'b0;
			goReg <= 1'b0;
			chanReg <= ARF_CHS_W'(ARF_BYTE_ZERO);
		end
		else
		begin
			if (ctrl0Wr)
			begin
				onReg <= writedata[ARF_ON_BIT];
				chanReg <= writedata[ARF_CHS_LSB +: ARF_CHS_W];
				if (startReq)
					goReg <= 1'b1;
				else if (!writedata[ARF_GO_BIT] || !writedata[ARF_ON_BIT])
					goReg <= 1'b0; // Software stop
			end
			// Hardware end of conversion wins over a late write
			if (stateReg == ARF_ST_LOAD)
				goReg <= 1'b0;
		end
	end
	// converter_control_one: justify, clock and reference
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			justReg <= 1'b0;
			clkSelReg <= ARF_CLK_W'(ARF_BYTE_ZERO);
			refReg <= ARF_REF_W'(ARF_BYTE_ZERO);
		end
		else if (wrAcc && lane0 && (address == ARF_OFF_CTRL1))
		begin
			justReg <= writedata[ARF_JUST_BIT];
			clkSelReg <= writedata[ARF_CLK_LSB +: ARF_CLK_W];
			refReg <= writedata[ARF_REF_LSB +: ARF_REF_W];
		end
	end

	// Bit clock divider, restarted with each conversion
	always_ff @(posedge clk)
	begin
		if (!nrst || startReq || tick)
			divCntReg <= 7'h00;
		else if (stateReg == ARF_ST_CONV)
			divCntReg <= divCntReg + 7'h01;
	end

	// SAR sequencer: trial each bit from the top, one per tick
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			stateReg <= ARF_ST_IDLE;
			bitIdxReg <= ARF_TOP_BIT;
			sarReg <= ARF_RES_ZERO;
			lastBitReg <= 1'b0;
			loadValReg <= ARF_RES_ZERO;
			loadAbortReg <= 1'b0;
		end
		else
		begin
			case (stateReg)
				ARF_ST_IDLE:
				begin
					if (startReq)
					begin
						// No bit decided yet, so an early abort fills zero
						bitIdxReg <= ARF_TOP_BIT;
						sarReg <= arfMask(ARF_TOP_BIT);
						lastBitReg <= 1'b0;
						stateReg <= ARF_ST_CONV;
					end
				end
				ARF_ST_CONV:
				begin
					if (abortReq)
					begin
						loadValReg <= partial;
						loadAbortReg <= 1'b1;
						stateReg <= ARF_ST_LOAD;
					end
					else if (tick)
					begin
						lastBitReg <= cmpSync;
						if (bitIdxReg == 4'h0)
						begin
							loadValReg <= decided;
							loadAbortReg <= 1'b0;
							sarReg <= decided;
							stateReg <= ARF_ST_LOAD;
						end
						else
						begin
							sarReg <= decided | arfMask(bitIdxReg - 4'h1);
							bitIdxReg <= bitIdxReg - 4'h1;
						end
					end
				end
				ARF_ST_LOAD:
					stateReg <= ARF_ST_IDLE;
				default:
					stateReg <= ARF_ST_IDLE;
			endcase
		end
	end

	// Result bytes: software writes, hardware loads win; no reset term
	always_ff @(posedge clk)
	begin
		if (stateReg == ARF_ST_LOAD)
		begin
			// Pads come out zero from the formatter
			resHiReg <= fmt.hi;
			resLoReg <= fmt.lo;
		end
		else if (wrAcc && lane0)
		begin
			if (address == ARF_OFF_RESH)
				resHiReg <= writedata[ARF_BYTE_W-1:0];
			if (address == ARF_OFF_RESL)
				resLoReg <= writedata[ARF_BYTE_W-1:0];
		end
	end

	// Enable mask register
	always_ff @(posedge clk)
	begin
		if (!nrst)
			enReg <= ARF_IRQ_W'(ARF_BYTE_ZERO);
		else if (wrAcc && lane0 && (address == ARF_OFF_IEN))
			enReg <= writedata[ARF_IRQ_W-1:0];
	end

	// Sticky status: set beats a simultaneous clear
	always_ff @(posedge clk)
	begin
		if (!nrst)
			statReg <= ARF_IRQ_W'(ARF_BYTE_ZERO);
		else
		begin
			if (wrAcc && lane0 && (address == ARF_OFF_ICLR))
				statReg <= statReg & ~writedata[ARF_IRQ_W-1:0];
			if (stateReg == ARF_ST_LOAD)
			begin
				if (loadAbortReg)
					statReg[ARF_EV_ABORT] <= 1'b1;
				else
					statReg[ARF_EV_DONE] <= 1'b1;
			end
		end
	end

	// Interrupt level, registered
	always_ff @(posedge clk)
	begin
		if (!nrst)
			irqReg <= 1'b0;
		else
			irqReg <= |(statReg & enReg);
	end

	// Outputs straight from flip-flops
	assign readdata = rdataReg;
	assign waitrequest = waitReg;
	assign irq = irqReg;
	assign dacCode = sarReg;
	assign inputChannelSelect = chanReg;
	assign refSelect = refReg;
	assign converterOn = onReg;

endmodule

// File: testbench/arf_result_regs_monitor.sv
// Bus, interrupt and result byte checks for the result register block
`timescale 1ns/1ps
module arf_result_regs_monitor #(
	parameter logic [6:0] FRC_DIV = 7'h04 // Same divide as the design
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Avalon-MM slave
	input wire logic [arf_pkg::ARF_ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [arf_pkg::ARF_DATA_W-1:0] writedata,
	input wire logic [arf_pkg::ARF_DATA_W-1:0] readdata,
	input wire logic waitrequest,
	// Interrupt and analog side
	input wire logic irq,
	input wire logic cmpIn,
	input wire logic [arf_pkg::ARF_RES_W-1:0] dacCode,
	input wire logic [arf_pkg::ARF_CHS_W-1:0] inputChannelSelect,
	input wire logic [arf_pkg::ARF_REF_W-1:0] refSelect,
	input wire logic converterOn
);
	import arf_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	logic [31:0] lastWd; // Write data one cycle back
	logic justReg; // Shadow of the justify bit
	logic freshReg; // Bytes will hold a hardware load, no software value
	logic [1:0] ienReg; // Shadow of the enable register
	wire wrOk = write && !waitrequest && byteenable[0]; // Accepted write
	// Last write data, for one-cycle-late field checks
	always_ff @(posedge clk)
		lastWd <= writedata;
	// Shadows; a software byte write makes the bytes untrustworthy
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			justReg <= 1'b0;
			freshReg <= 1'b0;
			ienReg <= 2'h0;
		end
		else if (wrOk)
		begin
			if (address == ARF_OFF_CTRL1)
				justReg <= writedata[7];
			if (address == ARF_OFF_IEN)
				ienReg <= writedata[1:0];
			if (address == ARF_OFF_CTRL0)
				freshReg <= writedata[0] && writedata[1];
			if (address == ARF_OFF_RESH || address == ARF_OFF_RESL)
				freshReg <= 1'b0;
		end
	end
	// Steps of an access and of a result read
	sequence reqOpen;
		(read || write) && waitrequest;
	endsequence
	sequence rdHi;
		read && !waitrequest && address == ARF_OFF_RESH && freshReg;
	endsequence
	sequence rdLo;
		read && !waitrequest && address == ARF_OFF_RESL && freshReg;
	endsequence
	sequence ienOff;
		ienReg == 2'h0;
	endsequence
	a_wait_one_cycle:
		assert property (reqOpen |=> !waitrequest ##1 waitrequest)
		else $error("waitrequest not low for one cycle");
	a_chan_follows:
		assert property (wrOk && address == ARF_OFF_CTRL0
			|=> inputChannelSelect == lastWd[6:2] && converterOn == lastWd[0])
		else $error("channel or enable not taken from write");
	a_ref_follows:
		assert property (wrOk && address == ARF_OFF_CTRL1
			|=> refSelect == lastWd[2:0])
		else $error("reference select not taken from write");
	a_irq_masked:
		assert property (ienOff ##1 ienOff |-> !irq)
		else $error("irq high with all events masked");
	a_left_high:
		assert property (rdHi |-> justReg
			|| readdata == {24'h000000, dacCode[9:2]})
		else $error("left high byte wrong");
	a_left_low:
		assert property (rdLo |-> justReg
			|| readdata == {24'h000000, dacCode[1:0], 6'h00})
		else $error("left low byte wrong");
	a_right_high:
		assert property (rdHi |-> !justReg
			|| readdata == {22'h00000, dacCode[9:8]})
		else $error("right high byte wrong");
	a_right_low:
		assert property (rdLo |-> !justReg
			|| readdata == {24'h000000, dacCode[7:0]})
		else $error("right low byte wrong");
endmodule
bind arf_result_regs arf_result_regs_monitor #(.FRC_DIV(FRC_DIV)) mon (
	.clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
	.byteenable(byteenable), .writedata(writedata), .readdata(readdata),
	.waitrequest(waitrequest), .irq(irq), .cmpIn(cmpIn), .dacCode(dacCode),
	.inputChannelSelect(inputChannelSelect), .refSelect(refSelect),
	.converterOn(converterOn));

// File: testbench/testbench.sv
// Self-checking bench for the converter result register block
`timescale 1ns/1ps
module testbench;
	import arf_pkg::*;
	localparam int ACQ = 50; // Acquisition wait in clocks, arbitrary
	logic clk = 1'b0; // System clock
	logic nrst = 1'b0; // Synchronous reset
	logic [4:0] address = 5'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [3:0] byteenable = 4'hF;
	logic [31:0] writedata = 32'h00000000;
	logic [31:0] readdata;
	logic waitrequest;
	logic irq;
	logic cmpIn = 1'b0; // Faked comparator decision
	logic [9:0] dacCode;
	logic [4:0] inputChannelSelect;
	logic [2:0] refSelect;
	logic converterOn;
	int numErrors = 0;
	int nTests = 0;
	int target = 0; // Analog level expressed as a code
	logic [31:0] seed = 32'h00006D0A; // Xorshift state
	logic [31:0] rd; // Last read data
	logic [4:0] zeroRegs[5] = '{5'h00, 5'h04, 5'h10, 5'h14, 5'h18};
	always #5 clk = ~clk;
	// Ideal analog side: input at or above the trial code keeps the bit
	always @(posedge clk)
		cmpIn <= (target >= int'(dacCode));
	arf_result_regs DUT (.clk(clk), .nrst(nrst), .address(address),
		.read(read), .write(write), .byteenable(byteenable),
		.writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .irq(irq), .cmpIn(cmpIn),
		.dacCode(dacCode), .inputChannelSelect(inputChannelSelect),
		.refSelect(refSelect), .converterOn(converterOn));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Reference placement of a result into one byte
	function automatic logic [31:0] fmt(input int r, input bit rj,
		input bit lo);
		if (lo)
			return 32'(rj ? r % 256 : (r % 4) * 64);
		return 32'(rj ? r / 256 : r / 4);
	endfunction
	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		nTests++;
		if (seen !== exp)
		begin
			numErrors++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	// One bus access; held until the edge that sees waitrequest low
	task automatic acc(input bit rw, input logic [4:0] a,
		input logic [7:0] d);
		@(posedge clk);
		address <= a;
		writedata <= {24'h000000, d};
		read <= !rw;
		write <= rw;
		do @(posedge clk); while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	// Run one conversion, optionally aborted, and check what it leaves
	// r is the result the rules predict; cs is the clock select code
	task automatic convert(input int t, input bit rj, input bit en,
		input int abortAt, input int r, input logic [2:0] cs);
		logic [7:0] c0;
		c0 = 8'(rnd());
		c0 = {1'b0, c0[6:2], 2'h1};
		target = t;
		acc(1, ARF_OFF_CTRL1, {rj, cs, 4'h0});
		// Both events enabled together, so irq follows en either way
		acc(1, ARF_OFF_IEN, {6'h00, en, en});
		acc(1, ARF_OFF_CTRL0, c0);
		repeat (ACQ) @(posedge clk);
		acc(1, ARF_OFF_CTRL0, c0 | 8'h02);
		if (abortAt > 0)
		begin
			repeat (abortAt) @(posedge clk);
			acc(1, ARF_OFF_CTRL0, c0);
		end
		do acc(0, ARF_OFF_CTRL0, 8'h00); while (rd[1] !== 1'b0);
		chk("control", rd, {24'h000000, c0});
		repeat (2) @(negedge clk);
		chk("irq", irq, en);
		acc(0, ARF_OFF_ISTAT, 8'h00);
		chk("status", rd, abortAt > 0 ? 2 : 1);
		acc(0, ARF_OFF_RESH, 8'h00);
		chk("high byte", rd, fmt(r, rj, 0));
		acc(0, ARF_OFF_RESL, 8'h00);
		chk("low byte", rd, fmt(r, rj, 1));
		acc(1, ARF_OFF_ICLR, 8'h03);
		repeat (2) @(negedge clk);
		chk("irq cleared", irq, 1'b0);
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", nTests, numErrors);
		if (numErrors == 0 && nTests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Five conversions of at most 320 clocks each plus bus traffic
	initial
	begin
		repeat (20000) @(posedge clk);
		numErrors++;
		summarize();
	end
	initial
	begin
		logic [7:0] h;
		logic [7:0] l;
		int v;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		foreach (zeroRegs[i])
		begin
			acc(0, zeroRegs[i], 8'h00);
			chk("reset value", rd, 32'h00000000);
		end
		acc(1, 5'h1C, 8'hFF);
		acc(0, 5'h1C, 8'h00);
		chk("unmapped", rd, 32'h00000000);
		// Go in the same write that turns the converter on is ignored
		acc(1, ARF_OFF_CTRL0, 8'h03);
		acc(0, ARF_OFF_CTRL0, 8'h00);
		chk("go with on", rd, 32'h00000001);
		h = 8'(rnd());
		l = 8'(rnd());
		acc(1, ARF_OFF_RESH, h);
		acc(1, ARF_OFF_RESL, l);
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		acc(0, ARF_OFF_RESH, 8'h00);
		chk("high kept", rd, {24'h000000, h});
		acc(0, ARF_OFF_RESL, 8'h00);
		chk("low kept", rd, {24'h000000, l});
		// Clock codes 1 to 4: divide by 8, by 32, the RC stand-in, by 4
		for (int i = 0; i < 4; i++)
		begin
			v = int'(rnd() % 1024);
			convert(v, i[0], i[1], 0, v, 3'(i + 1));
		end
		// Divide by 64: bits 9..6 decide 1,0,1,0 before the stop, so the
		// unconverted bits copy the last decided zero
		convert(32'h2BF, 1'b0, 1'b1, 300, 32'h280, 3'h6);
		summarize();
	end
endmodule
